// >>> hw/baud_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef BAUD_PARAMS_SVH
`define BAUD_PARAMS_SVH
`define OFF_DIVIDER_CONTROL   8'h00
`define OFF_FRACTION_K        8'h04
`define OFF_FIFO_CONFIG       8'h08
`define OFF_CHANNEL_CONTROL   8'h0c
`define OFF_CHANNEL_STATUS    8'h10
`define OFF_SOFT_RESET        8'h14
`define DIVIDER_CONTROL_RESET 8'h00
`define FRACTION_K_RESET      4'h0
`define FIFO_CONFIG_RESET     5'h00
`define FRAC_ENABLE_BIT       6
`define CLK_SEL_HI            5
`define CLK_SEL_LO            4
`define DIVISOR_HI            3
`define DIVISOR_LO            0
`define CTL_RX_ENABLE_BIT     0
`define CTL_TX_ENABLE_BIT     1
`define CTL_UART_MODE_BIT     2
`define CTL_DOUBLE_BUF_BIT    3
`define SOFT_RESET_ARM        2'b10
`define SOFT_RESET_FIRE       2'b01
`define SOFT_RESET_DELAY      2'h2
`endif

// >>> hw/baud_pkg.sv
// types shared by the baud generator and soft reset block
package baud_pkg;
  typedef struct packed {
    logic       frac_enable;
    logic [1:0] clk_select;
    logic [3:0] divisor;
    logic [3:0] fraction_k;
  } divider_cfg_t;

  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic tx_running;
    logic overrun;
    logic parity;
    logic framing;
  } channel_flags_t;

  typedef enum logic [2:0] {
    sr_idle  = 3'b001,
    sr_armed = 3'b010,
    sr_wait  = 3'b100
  } soft_reset_state_t;
endpackage : baud_pkg

// >>> hw/baud_tick_gen.sv
// prescaler tap select and N or N+(16-K)/16 divider producing baud ticks
`timescale 1ns/1ps
`include "baud_params.svh"
module baud_tick_gen
  import baud_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         clear,
  input  wire divider_cfg_t cfg,
  output logic              tick
);
  logic [5:0] prescale;
  logic       tap_pulse;
  logic [4:0] count;
  logic [4:0] n_value;
  logic [4:0] period;
  logic [4:0] next_accum;
  logic [4:0] accum;

  // free running prescaler giving div1/4/16/64 tap pulses
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      prescale <= 6'h00;
    end else if (ce) begin
      prescale <= prescale + 6'h01;
    end
  end

  always_comb begin
    unique case (cfg.clk_select)
      2'b00: tap_pulse = 1'b1;
      2'b01: tap_pulse = (prescale[1:0] == 2'h3);
      2'b10: tap_pulse = (prescale[3:0] == 4'hf);
      2'b11: tap_pulse = (prescale[5:0] == 6'h3f);
    endcase
  end

  // code 0 means sixteen
  assign n_value = (cfg.divisor == 4'h0) ? 5'h10 : {1'b0, cfg.divisor};

  // distribute 16-K extra cycles evenly over sixteen periods
  assign next_accum = accum + 5'(5'h10 - {1'b0, cfg.fraction_k});
  assign period = (cfg.frac_enable && next_accum[4]) ? n_value + 5'h01
                                                     : n_value;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count <= 5'h00;
      accum <= 5'h00;
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (tap_pulse) begin
        if (count + 5'h01 >= period) begin
          count <= 5'h00;
          tick  <= 1'b1;
          accum <= cfg.frac_enable ? {1'b0, next_accum[3:0]} : 5'h00;
        end else begin
          count <= count + 5'h01;
        end
      end
    end
  end
endmodule : baud_tick_gen

// >>> hw/serial_baud_gen_soft_reset.sv
// serial channel baud generator registers and two-write soft reset
`timescale 1ns/1ps
`include "baud_params.svh"
module serial_baud_gen_soft_reset
  import baud_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        set_tx_empty,
  input  wire logic        set_rx_full,
  input  wire logic        set_tx_running,
  input  wire logic        set_overrun,
  input  wire logic        set_parity,
  input  wire logic        set_framing,
  output logic             baud_tick,
  output logic             rx_enable,
  output logic             tx_enable,
  output logic             uart_mode,
  output logic             double_buffer,
  output logic [4:0]       fifo_config,
  output logic             soft_reset_pulse
);
  divider_cfg_t      cfg;
  channel_flags_t    flags;
  soft_reset_state_t sr_state;
  logic [1:0]        sr_delay;
  logic [7:0]        aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  logic              do_write;
  logic              addr_ok;
  logic              soft_reset_write;

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == `OFF_DIVIDER_CONTROL) || (addr == `OFF_FRACTION_K)
          || (addr == `OFF_FIFO_CONFIG) || (addr == `OFF_CHANNEL_CONTROL)
          || (addr == `OFF_CHANNEL_STATUS) || (addr == `OFF_SOFT_RESET);
  endfunction : mapped

  // write channel: address and data latched independently
  // a frozen slave must not complete a handshake it cannot record
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign addr_ok       = mapped(aw_addr);
  assign soft_reset_write = do_write && (aw_addr == `OFF_SOFT_RESET)
                         && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // divider and fifo configuration registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.frac_enable <= 1'b0;
      cfg.clk_select  <= 2'h0;
      cfg.divisor     <= 4'h0;
      cfg.fraction_k  <= `FRACTION_K_RESET;
      fifo_config     <= `FIFO_CONFIG_RESET;
    end else if (ce && do_write && w_strb[0]) begin
      if (aw_addr == `OFF_DIVIDER_CONTROL) begin
        cfg.frac_enable <= w_data[`FRAC_ENABLE_BIT];
        cfg.clk_select  <= w_data[`CLK_SEL_HI:`CLK_SEL_LO];
        cfg.divisor     <= w_data[`DIVISOR_HI:`DIVISOR_LO];
      end
      if (aw_addr == `OFF_FRACTION_K) begin
        cfg.fraction_k <= w_data[3:0];
      end
      if (aw_addr == `OFF_FIFO_CONFIG) begin
        fifo_config <= w_data[4:0];
      end
    end
  end

  // two-write recognition, then a fixed wait before execution
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_state         <= sr_idle;
      sr_delay         <= 2'h0;
      soft_reset_pulse <= 1'b0;
    end else if (ce) begin
      soft_reset_pulse <= 1'b0;
      unique case (sr_state)
        sr_idle: begin
          if (soft_reset_write && w_data[1:0] == `SOFT_RESET_ARM) begin
            sr_state <= sr_armed;
          end
        end
        sr_armed: begin
          if (soft_reset_write) begin
            if (w_data[1:0] == `SOFT_RESET_FIRE) begin
              sr_state <= sr_wait;
              sr_delay <= `SOFT_RESET_DELAY - 2'h1;
            end else if (w_data[1:0] != `SOFT_RESET_ARM) begin
              sr_state <= sr_idle;
            end
          end
        end
        sr_wait: begin
          if (sr_delay == 2'h0) begin
            soft_reset_pulse <= 1'b1;
            sr_state         <= sr_idle;
          end else begin
            sr_delay <= sr_delay - 2'h1;
          end
        end
        default: sr_state <= sr_idle;
      endcase
    end
  end

  // channel control: enables and mode bits; soft reset clears the enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_enable     <= 1'b0;
      tx_enable     <= 1'b0;
      uart_mode     <= 1'b0;
      double_buffer <= 1'b0;
    end else if (ce) begin
      if (soft_reset_pulse) begin
        rx_enable <= 1'b0;
        tx_enable <= 1'b0;
      end else if (do_write && w_strb[0]
                   && aw_addr == `OFF_CHANNEL_CONTROL) begin
        rx_enable     <= w_data[`CTL_RX_ENABLE_BIT];
        tx_enable     <= w_data[`CTL_TX_ENABLE_BIT];
        uart_mode     <= w_data[`CTL_UART_MODE_BIT];
        double_buffer <= w_data[`CTL_DOUBLE_BUF_BIT];
      end
    end
  end

  // status flags follow the engine; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else if (ce) begin
      if (soft_reset_pulse) begin
        flags <= '0;
      end
      if (set_tx_empty)   flags.tx_empty   <= 1'b1;
      if (set_rx_full)    flags.rx_full    <= 1'b1;
      if (set_tx_running) flags.tx_running <= 1'b1;
      if (set_overrun)    flags.overrun    <= 1'b1;
      if (set_parity)     flags.parity     <= 1'b1;
      if (set_framing)    flags.framing    <= 1'b1;
    end
  end

  // read channel: one cycle after arvalid is taken
  assign s_axi_arready = ce && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00}) ? 2'h0 : 2'h2;
        unique case ({s_axi_araddr[7:2], 2'b00})
          `OFF_DIVIDER_CONTROL: s_axi_rdata <= {25'h0, cfg.frac_enable,
                                     cfg.clk_select, cfg.divisor};
          `OFF_FRACTION_K:      s_axi_rdata <= {28'h0, cfg.fraction_k};
          `OFF_FIFO_CONFIG:     s_axi_rdata <= {27'h0, fifo_config};
          `OFF_CHANNEL_CONTROL: s_axi_rdata <= {28'h0, double_buffer,
                                     uart_mode, tx_enable, rx_enable};
          `OFF_CHANNEL_STATUS:  s_axi_rdata <= {26'h0, flags};
          `OFF_SOFT_RESET:      s_axi_rdata <= {30'h0,
                                     (sr_state == sr_armed), 1'b0};
          default:              s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  baud_tick_gen u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .clear   (soft_reset_pulse),
    .cfg     (cfg),
    .tick    (baud_tick)
  );
endmodule : serial_baud_gen_soft_reset

// >>> test/baud_monitor.sv
// concurrent checks on the register bus and soft reset outputs
`timescale 1ns/1ps
module baud_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx_enable,
  input wire logic        tx_enable,
  input wire logic        soft_reset_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // only the firing code can launch the countdown
  wire fire = wr_take && s_axi_awaddr == 8'h14 && s_axi_wdata[1:0] == 2'b01;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  a_fire_delay: assert property (
    soft_reset_pulse |-> $past(fire, 4)) else $error("soft reset mistimed");
  a_pulse_single: assert property (
    soft_reset_pulse |=> !soft_reset_pulse) else $error("pulse too long");
  a_reset_clears: assert property (
    soft_reset_pulse |=> !rx_enable && !tx_enable) else $error("enables kept");
  a_write_answer: assert property (
    wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_b_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_busy_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("busy taken");
  a_read_answer: assert property (
    rd_take |=> s_axi_rvalid) else $error("read answer late");
  a_unmapped_err: assert property (
    rd_take && s_axi_araddr[7:2] > 6'h05 |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  a_r_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read answer dropped");
endmodule : baud_monitor

// >>> test/flag_engine.sv
// shift engine stand-in that raises status flags on request
`timescale 1ns/1ps
module flag_engine (
  input wire logic       aclk,
  input wire logic [5:0] req,
  output logic           set_tx_empty,
  output logic           set_rx_full,
  output logic           set_tx_running,
  output logic           set_overrun,
  output logic           set_parity,
  output logic           set_framing
);
  // one cycle behind the request, as a registered engine would be
  always_ff @(posedge aclk) begin
    {set_tx_empty, set_rx_full, set_tx_running} <= req[5:3];
    {set_overrun, set_parity, set_framing} <= req[2:0];
  end
endmodule : flag_engine

// >>> test/serial_baud_gen_soft_reset_tb.sv
// register, tick and soft reset tests for the baud block
`timescale 1ns/1ps
module serial_baud_gen_soft_reset_tb;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, bseen;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, baud_tick, rx_enable, tx_enable, uart_mode;
  logic double_buffer, soft_reset_pulse;
  logic set_tx_empty, set_rx_full, set_tx_running;
  logic set_overrun, set_parity, set_framing;
  logic [4:0] fifo_config;
  logic [5:0] req = 0;
  logic [7:0] cfg [4] = '{8'h03, 8'h00, 8'h31, 8'h12};
  int per [4] = '{3, 16, 64, 8};
  int bad_count = 0, n_checks = 0, pulses = 0, p, s;
  serial_baud_gen_soft_reset u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .set_tx_empty, .set_rx_full, .set_tx_running, .set_overrun,
    .set_parity, .set_framing, .baud_tick, .rx_enable, .tx_enable,
    .uart_mode, .double_buffer, .fifo_config, .soft_reset_pulse);
  flag_engine u_eng (.aclk, .req, .set_tx_empty, .set_rx_full,
    .set_tx_running, .set_overrun, .set_parity, .set_framing);
  always #4 aclk = ~aclk;
  always @(posedge aclk) if (soft_reset_pulse === 1'b1) pulses++;
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task guard(input int n);
    if (n > 2000) begin
      bad_count++;
      $display("[FAIL] %0t wait ran out", $time);
      wrap_up();
    end
  endtask : guard
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    int n;
    aw_ok = 0; w_ok = 0; n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk); n++; guard(n);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1; s_axi_awvalid <= 0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1; s_axi_wvalid <= 0;
      end
    end
    do begin @(posedge aclk); n++; guard(n); end while (s_axi_bvalid !== 1);
    bseen = s_axi_bresp; s_axi_bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin @(posedge aclk); n++; guard(n); end while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do begin @(posedge aclk); n++; guard(n); end while (s_axi_rvalid !== 1);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
  endtask : rd
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(d, exp);
  endtask : rchk
  // first tick only aligns, then k back-to-back intervals are summed
  task period(input int k, output int q);
    int n;
    n = 0;
    do begin @(posedge aclk); n++; guard(n); end while (baud_tick !== 1);
    q = 0;
    repeat (k) begin
      do begin @(posedge aclk); q++; guard(q); end while (baud_tick !== 1);
    end
  endtask : period
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    for (int a = 0; a <= 16; a += 4) rchk(a, 0);
    rd(8'h18); check(r, 2'b10); check(d, 0);
    wr(8'h18, 32'hff); check(bseen, 2'b10);
    wr(8'h08, 32'hff); rchk(8'h08, 32'h1f); check(fifo_config, 5'h1f);
    wr(8'h04, 32'hff); rchk(8'h04, 32'h0f);
    wr(8'h0c, 32'h04);
    wr(8'h00, 32'h75); rchk(8'h00, 32'h75);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        wr(8'h0c, 32'h08);
        check({uart_mode, double_buffer}, 2'b01);
      end
      wr(8'h00, cfg[i]);
      period(1, p); period(1, p);
      check(p, per[i]);
    end
    $display("test integer divide done");
    wr(8'h04, 32'h0c);
    wr(8'h0c, 32'h04); wr(8'h00, 32'h43);
    period(1, p); period(16, s);
    check(s, 16 * 3 + 16 - 12);
    // with the enable low the tick register must stay frozen at zero
    period(1, p); ce <= 0; s = 0;
    repeat (20) begin @(posedge aclk); s += baud_tick; end
    ce <= 1; check(s, 0);
    $display("test fractional divide done");
    wr(8'h0c, 32'h0f); check({rx_enable, tx_enable}, 2'b11);
    check({uart_mode, double_buffer}, 2'b11);
    @(posedge aclk) req <= 6'h3f;
    @(posedge aclk) req <= 6'h00;
    repeat (2) @(posedge aclk);
    rchk(8'h10, 32'h3f);
    wr(8'h14, 1); wr(8'h14, 2); rchk(8'h14, 2); wr(8'h14, 3); wr(8'h14, 1);
    repeat (8) @(posedge aclk);
    check(pulses, 0);
    for (int i = 0; i < 2; i++) begin wr(8'h14, 2); wr(8'h14, 1); end
    repeat (8) @(posedge aclk);
    check(pulses, 2);
    check({rx_enable, tx_enable}, 2'b00);
    rchk(8'h10, 0); rchk(8'h0c, 32'h0c);
    $display("test soft reset done");
    wrap_up();
  end
endmodule : serial_baud_gen_soft_reset_tb
bind serial_baud_gen_soft_reset baud_monitor u_mon (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .rx_enable, .tx_enable, .soft_reset_pulse);
